//--- core/flash_mass_erase_sequencer.sv
`timescale 1ns/1ps
module flash_mass_erase_sequencer
  import mass_erase_pkg::*;
#(
  parameter int EV_ALL_CYCLES = EV_ALL_BUS,
  parameter int EV_PFLASH_CYCLES = EV_PFLASH_BUS,
  parameter int EV_EEPROM_CYCLES = EV_EEPROM_BUS,
  parameter int EV_SECTION_CYCLES = EV_SECTION_BUS,
  parameter int PGM4_PE_CYCLES = PGM4_PE,
  parameter int PGM4_BUS_CYCLES = PGM4_BUS,
  parameter int ERASE_PE_CYCLES = ERASE_ALL_PE,
  parameter int ERASE_BUS_CYCLES = ERASE_ALL_BUS
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire cmd_req_type cmd_req,
  input wire logic mode_permits_erase_all,
  input wire logic pflash_protected,
  input wire logic eeprom_protected,
  input wire logic mass_erase_req,
  input wire logic divider_write,
  input wire logic [DIV_W-1:0] divider_wdata,
  input wire logic clear_access_error,
  input wire logic clear_protection_violation,
  input wire logic pe_tick,
  input wire verify_result_type verify_result,
  output flash_status_type flash_status_reg,
  output logic busy,
  output logic mass_erase_pending,
  output logic [DIV_W-1:0] nvm_clock_divider,
  output logic divider_loaded,
  output logic [SEC_W-1:0] security_state_field,
  output logic [SEC_BYTE_W-1:0] security_byte,
  output logic array_erase,
  output logic array_verify,
  output logic array_program
);

  // ------------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_VERIFY,
    ST_PROGRAM,
    ST_FINISH
  } seq_state_type;

  seq_state_type state_q;
  cmd_type cmd_q;
  logic pin_run_q;
  logic req_prev_q;
  logic timer_start_q;
  logic [COUNT_W-1:0] timer_pe_q;
  logic [COUNT_W-1:0] timer_bus_q;
  logic timer_done;
  logic req_rise;
  logic pin_start;
  logic cmd_start;
  logic set_access_error;
  logic set_protection_violation;
  logic erase_all_ok;

  assign req_rise = mass_erase_req && !req_prev_q;

  nvm_phase_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .start(timer_start_q),
    .pe_cycles(timer_pe_q),
    .bus_cycles(timer_bus_q),
    .pe_tick(pe_tick),
    .done(timer_done)
  );

  // ------------------------------------------------------------------
  // Request checks
  // ------------------------------------------------------------------
  // The pin takes precedence over a software launch in the same cycle.
  always_comb begin
    set_access_error = 1'b0;
    set_protection_violation = 1'b0;
    pin_start = 1'b0;
    cmd_start = 1'b0;
    erase_all_ok = 1'b0;
    if (state_q == ST_IDLE) begin
      if (req_rise) begin
        if (!mode_permits_erase_all) begin
          set_access_error = 1'b1;
        end else if (!divider_loaded) begin
          set_access_error = 1'b1;
        end else begin
          pin_start = 1'b1;
        end
      end else if (cmd_req.launch) begin
        if (!divider_loaded) begin
          set_access_error = 1'b1;
        end else if (cmd_req.code == CMD_ERASE_ALL) begin
          if (cmd_req.command_word_index != INDEX_FIRST) begin
            set_access_error = 1'b1;
          end else if (!mode_permits_erase_all) begin
            set_access_error = 1'b1;
          end else if (pflash_protected || eeprom_protected) begin
            set_protection_violation = 1'b1;
          end else begin
            erase_all_ok = 1'b1;
          end
        end else begin
          cmd_start = 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin edge detection
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      req_prev_q <= 1'b0;
    end else if (clk_en) begin
      req_prev_q <= mass_erase_req;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer and phase timing
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_ERASE_VERIFY_ALL;
      pin_run_q <= 1'b0;
      timer_start_q <= 1'b0;
      timer_pe_q <= COUNT_NONE;
      timer_bus_q <= COUNT_NONE;
    end else if (clk_en) begin
      timer_start_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (pin_start || erase_all_ok) begin
            state_q <= ST_ERASE;
            cmd_q <= CMD_ERASE_ALL;
            pin_run_q <= pin_start;
            timer_start_q <= 1'b1;
            timer_pe_q <= COUNT_W'(ERASE_PE_CYCLES);
            timer_bus_q <= COUNT_W'(ERASE_BUS_CYCLES);
          end else if (cmd_start) begin
            cmd_q <= cmd_req.code;
            timer_start_q <= 1'b1;
            unique case (cmd_req.code)
              CMD_PROGRAM_PFLASH: begin
                state_q <= ST_PROGRAM;
                timer_pe_q <= COUNT_W'(PGM4_PE_CYCLES);
                timer_bus_q <= COUNT_W'(PGM4_BUS_CYCLES);
              end
              CMD_ERASE_VERIFY_PFLASH: begin
                state_q <= ST_VERIFY;
                timer_pe_q <= COUNT_NONE;
                timer_bus_q <= COUNT_W'(EV_PFLASH_CYCLES);
              end
              CMD_ERASE_VERIFY_EEPROM: begin
                state_q <= ST_VERIFY;
                timer_pe_q <= COUNT_NONE;
                timer_bus_q <= COUNT_W'(EV_EEPROM_CYCLES);
              end
              CMD_ERASE_VERIFY_SECTION: begin
                state_q <= ST_VERIFY;
                timer_pe_q <= COUNT_NONE;
                timer_bus_q <= COUNT_W'(EV_SECTION_CYCLES);
              end
              default: begin
                state_q <= ST_VERIFY;
                timer_pe_q <= COUNT_NONE;
                timer_bus_q <= COUNT_W'(EV_ALL_CYCLES);
              end
            endcase
          end
        end
        ST_ERASE: begin
          if (timer_done) begin
            state_q <= ST_VERIFY;
            timer_start_q <= 1'b1;
            timer_pe_q <= COUNT_NONE;
            timer_bus_q <= COUNT_W'(EV_ALL_CYCLES);
          end
        end
        ST_VERIFY: begin
          if (timer_done) begin
            if (cmd_q == CMD_ERASE_ALL && !verify_result.fail) begin
              state_q <= ST_PROGRAM;
              timer_start_q <= 1'b1;
              timer_pe_q <= COUNT_W'(PGM4_PE_CYCLES);
              timer_bus_q <= COUNT_W'(PGM4_BUS_CYCLES);
            end else begin
              state_q <= ST_FINISH;
            end
          end
        end
        ST_PROGRAM: begin
          if (timer_done) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
          pin_run_q <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------
  // A hardware set in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flash_status_reg <= '0;
    end else if (clk_en) begin
      flash_status_reg.access_error_flag <=
        (flash_status_reg.access_error_flag && !clear_access_error) || set_access_error;
      flash_status_reg.protection_violation_flag <=
        (flash_status_reg.protection_violation_flag && !clear_protection_violation) ||
        set_protection_violation;
      if (pin_start || erase_all_ok || cmd_start) begin
        flash_status_reg.verify_error_flag <= 1'b0;
        flash_status_reg.uncorrectable_verify_flag <= 1'b0;
      end else if (timer_done && (state_q == ST_VERIFY || state_q == ST_PROGRAM)) begin
        if (verify_result.fail) begin
          flash_status_reg.verify_error_flag <= 1'b1;
        end
        if (verify_result.fail && verify_result.uncorrectable) begin
          flash_status_reg.uncorrectable_verify_flag <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Pending, busy and array strobes
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mass_erase_pending <= 1'b0;
      busy <= 1'b0;
      array_erase <= 1'b0;
      array_verify <= 1'b0;
      array_program <= 1'b0;
    end else if (clk_en) begin
      if (pin_start) begin
        mass_erase_pending <= 1'b1;
      end else if (state_q == ST_FINISH) begin
        mass_erase_pending <= 1'b0;
      end
      if (pin_start || erase_all_ok || cmd_start) begin
        busy <= 1'b1;
      end else if (state_q == ST_FINISH) begin
        busy <= 1'b0;
      end
      // Protection inputs are only read by the request checks, never stored or changed.
      array_erase <= (state_q == ST_ERASE) && !timer_done;
      array_verify <= (state_q == ST_VERIFY) && !timer_done;
      array_program <= (state_q == ST_PROGRAM) && !timer_done;
    end
  end

  // ------------------------------------------------------------------
  // Clock divider
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nvm_clock_divider <= DIVIDER_RESET;
      divider_loaded <= 1'b0;
    end else if (clk_en) begin
      if (state_q == ST_FINISH && pin_run_q) begin
        nvm_clock_divider <= DIVIDER_RESET;
        divider_loaded <= 1'b0;
      end else if (divider_write && state_q == ST_IDLE && !busy) begin
        nvm_clock_divider <= divider_wdata;
        divider_loaded <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Security
  // ------------------------------------------------------------------
  // Only a fully verified erase-all, including the security byte
  // program step, releases security.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      security_state_field <= SEC_SECURED;
      security_byte <= SEC_BYTE_SECURED;
    end else if (clk_en) begin
      if (state_q == ST_PROGRAM && timer_done && cmd_q == CMD_ERASE_ALL &&
          !verify_result.fail) begin
        security_state_field <= SEC_UNSECURED;
        security_byte <= SEC_BYTE_UNSECURED;
      end
    end
  end

endmodule // flash_mass_erase_sequencer

//--- core/mass_erase_pkg.sv
// Overview of operation
// - Erase-all with nonzero word index: access error.
// - Erase-all in forbidden mode: access error.
// - Erase-all with any protection: violation, abort.
// - Erase-all verify failures set verify flags.
// - Request pin runs erase-all without software.
// - Pin with divider unloaded: no erase, access error.
// - Pin erase resets divider; software reloads it.
// - Pin erase ignores every protection setting.
// - Verify pass: unsecure field and security byte.
// - Pending bit high during pin erase only.
// - Protection configuration is never altered.
// - Pin erase flags erase/program verify failures.
// - Verify-all blocks: 33760 bus cycles.
// - Block verify: 33320 flash, 823 EEPROM.
// - Section verify: 505 bus cycles.
// - Program four words: 164 plus 3077 cycles.
package mass_erase_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int COUNT_W = 17;
  localparam int DIV_W = 8;
  localparam int INDEX_W = 3;
  localparam int SEC_W = 2;
  localparam int SEC_BYTE_W = 8;

  // ------------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIVIDER_RESET = 8'h00;
  localparam logic [INDEX_W-1:0] INDEX_FIRST = 3'h0;
  localparam logic [SEC_W-1:0] SEC_SECURED = 2'h3;
  localparam logic [SEC_W-1:0] SEC_UNSECURED = 2'h2;
  localparam logic [SEC_BYTE_W-1:0] SEC_BYTE_SECURED = 8'hFF;
  localparam logic [SEC_BYTE_W-1:0] SEC_BYTE_UNSECURED = 8'hFE;

  // ------------------------------------------------------------------
  // Cycle counts (bus cycles run on clk, program/erase cycles on ticks)
  // ------------------------------------------------------------------
  localparam int EV_ALL_BUS = 33760;
  localparam int EV_PFLASH_BUS = 33320;
  localparam int EV_EEPROM_BUS = 823;
  localparam int EV_SECTION_BUS = 505;
  localparam int PGM4_PE = 164;
  localparam int PGM4_BUS = 3077;
  localparam int ERASE_ALL_PE = 100066;
  localparam int ERASE_ALL_BUS = 34223;
  localparam logic [COUNT_W-1:0] COUNT_NONE = 17'h00000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_ERASE_VERIFY_ALL,
    CMD_ERASE_VERIFY_PFLASH,
    CMD_ERASE_VERIFY_EEPROM,
    CMD_ERASE_VERIFY_SECTION,
    CMD_PROGRAM_PFLASH,
    CMD_ERASE_ALL
  } cmd_type;

  typedef struct packed {
    logic launch;
    cmd_type code;
    logic [INDEX_W-1:0] command_word_index;
  } cmd_req_type;

  typedef struct packed {
    logic access_error_flag;
    logic protection_violation_flag;
    logic verify_error_flag;
    logic uncorrectable_verify_flag;
  } flash_status_type;

  typedef struct packed {
    logic fail;
    logic uncorrectable;
  } verify_result_type;

endpackage

//--- core/nvm_phase_timer.sv
`timescale 1ns/1ps
module nvm_phase_timer
  import mass_erase_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [COUNT_W-1:0] pe_cycles,
  input wire logic [COUNT_W-1:0] bus_cycles,
  input wire logic pe_tick,
  output logic done
);

  // Program/erase ticks are counted first, then bus cycles.
  logic [COUNT_W-1:0] pe_left_q;
  logic [COUNT_W-1:0] bus_left_q;
  logic running_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pe_left_q <= COUNT_NONE;
      bus_left_q <= COUNT_NONE;
      running_q <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start) begin
        pe_left_q <= pe_cycles;
        bus_left_q <= bus_cycles;
        running_q <= 1'b1;
      end else if (running_q) begin
        if (pe_left_q != COUNT_NONE) begin
          if (pe_tick) begin
            pe_left_q <= pe_left_q - 1'b1;
          end
        end else if (bus_left_q > 17'h00001) begin
          bus_left_q <= bus_left_q - 1'b1;
        end else begin
          bus_left_q <= COUNT_NONE;
          running_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // nvm_phase_timer

//--- verif/flash_mass_erase_sequencer_props.sv
`timescale 1ns/1ps
module sequencer_props
  import mass_erase_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire cmd_req_type cmd_req,
  input wire logic mode_permits_erase_all,
  input wire logic pflash_protected,
  input wire logic eeprom_protected,
  input wire logic mass_erase_req,
  input wire flash_status_type flash_status_reg,
  input wire logic busy,
  input wire logic mass_erase_pending,
  input wire logic [DIV_W-1:0] nvm_clock_divider,
  input wire logic divider_loaded,
  input wire logic [SEC_W-1:0] security_state_field,
  input wire logic [SEC_BYTE_W-1:0] security_byte
);
  // ----------------------------------------------------------------
  // Erase-all launch and pin checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire ea = clk_en && cmd_req.launch && !busy && !mass_erase_req && cmd_req.code == CMD_ERASE_ALL;
  wire pin_ok = clk_en && !busy && mode_permits_erase_all;
  chk_index_err: assert property (ea && cmd_req.command_word_index != INDEX_FIRST
    |=> flash_status_reg.access_error_flag && !busy) else $error("index error not flagged");
  chk_mode_err: assert property (ea && !mode_permits_erase_all
    |=> flash_status_reg.access_error_flag && !busy) else $error("mode error not flagged");
  chk_prot_viol: assert property (ea && cmd_req.command_word_index == INDEX_FIRST && mode_permits_erase_all
    && divider_loaded && (pflash_protected || eeprom_protected)
    |=> flash_status_reg.protection_violation_flag && !busy) else $error("protection not flagged");
  chk_pin_start: assert property ($rose(mass_erase_req) && pin_ok && divider_loaded
    |=> ##[0:1] busy && mass_erase_pending) else $error("pin erase did not start");
  chk_pin_div: assert property ($rose(mass_erase_req) && pin_ok && !divider_loaded
    |=> ##[0:1] flash_status_reg.access_error_flag && !mass_erase_pending) else $error("divider not checked");
  chk_div_reset: assert property ($fell(mass_erase_pending)
    |-> ##[0:2] nvm_clock_divider == DIVIDER_RESET && !divider_loaded) else $error("divider kept after pin erase");
  chk_sec_write: assert property ($past(resetn) && $changed(security_byte)
    |-> ##[0:1] security_byte == SEC_BYTE_UNSECURED && security_state_field == SEC_UNSECURED)
    else $error("bad security update");
  chk_pend_busy: assert property (mass_erase_pending |-> busy) else $error("pending while idle");
  chk_flag_pair: assert property (flash_status_reg.uncorrectable_verify_flag
    |-> flash_status_reg.verify_error_flag) else $error("uncorrectable without verify error");
endmodule // sequencer_props

bind flash_mass_erase_sequencer sequencer_props u_props (.*);

//--- verif/erase_requester.sv
`timescale 1ns/1ps
module erase_requester
  import mass_erase_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire flash_status_type flash_status_reg,
  output logic mass_erase_req,
  output logic clear_access_error,
  output logic clear_protection_violation
);
  // ----------------------------------------------------------------
  // Clears stale flags, then raises the request and holds it
  // ----------------------------------------------------------------
  initial begin
    mass_erase_req = 1'b0;
    clear_access_error = 1'b0;
    clear_protection_violation = 1'b0;
  end
  always @(negedge clk) begin
    clear_access_error <= 1'b0;
    clear_protection_violation <= 1'b0;
    if (!resetn || !go) begin
      mass_erase_req <= 1'b0;
    end else if (!mass_erase_req && (flash_status_reg.access_error_flag || flash_status_reg.protection_violation_flag)) begin
      clear_access_error <= flash_status_reg.access_error_flag;
      clear_protection_violation <= flash_status_reg.protection_violation_flag;
    end else begin
      mass_erase_req <= 1'b1;
    end
  end
endmodule // erase_requester

//--- verif/flash_mass_erase_sequencer_tb_top.sv
`timescale 1ns/1ps
module flash_mass_erase_sequencer_tb_top
  import mass_erase_pkg::*;
;
  typedef struct {
    cmd_type code;
    logic [2:0] idx;
    logic mode, pp, ep;
    logic [1:0] vr;
    logic [3:0] st;
    logic [1:0] sec;
    int n;
  } row_type;
  logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, divider_write = 1'b0, pe_tick = 1'b0, go = 1'b0;
  logic mode_permits_erase_all = 1'b1, pflash_protected = 1'b0, eeprom_protected = 1'b0;
  logic [DIV_W-1:0] divider_wdata = 8'h13;
  cmd_req_type cmd_req = '0;
  verify_result_type verify_result = '0;
  logic mass_erase_req, clear_access_error, clear_protection_violation;
  flash_status_type flash_status_reg;
  logic busy, mass_erase_pending, divider_loaded, array_erase, array_verify, array_program;
  logic [2:0] saw;
  logic [DIV_W-1:0] nvm_clock_divider;
  logic [SEC_W-1:0] security_state_field;
  logic [SEC_BYTE_W-1:0] security_byte;
  logic [1:0] tick_cnt = 2'h0;
  int fails = 0, n_checks = 0, len, base = -1;
  row_type r;
  row_type rows[12] = '{
    '{CMD_ERASE_VERIFY_SECTION, 3'h0, 1, 0, 0, 2'h0, 4'h0, 2'h3, EV_SECTION_BUS},
    '{CMD_ERASE_VERIFY_ALL, 3'h0, 0, 1, 1, 2'h0, 4'h0, 2'h3, 8},
    '{CMD_ERASE_VERIFY_PFLASH, 3'h0, 1, 0, 0, 2'h2, 4'h2, 2'h3, EV_PFLASH_BUS},
    '{CMD_ERASE_VERIFY_EEPROM, 3'h0, 1, 0, 0, 2'h3, 4'h3, 2'h3, EV_EEPROM_BUS},
    '{CMD_PROGRAM_PFLASH, 3'h0, 1, 0, 0, 2'h0, 4'h0, 2'h3, 0},
    '{CMD_ERASE_ALL, 3'h1, 1, 0, 0, 2'h0, 4'h8, 2'h3, 0},
    '{CMD_ERASE_ALL, 3'h7, 1, 0, 0, 2'h0, 4'h8, 2'h3, 0},
    '{CMD_ERASE_ALL, 3'h0, 0, 0, 0, 2'h0, 4'h8, 2'h3, 0},
    '{CMD_ERASE_ALL, 3'h0, 1, 1, 0, 2'h0, 4'h4, 2'h3, 0},
    '{CMD_ERASE_ALL, 3'h0, 1, 0, 1, 2'h0, 4'h4, 2'h3, 0},
    '{CMD_ERASE_ALL, 3'h0, 1, 0, 0, 2'h0, 4'h0, 2'h2, 0},
    '{CMD_ERASE_ALL, 3'h0, 1, 0, 0, 2'h3, 4'h3, 2'h3, 0}};

  // Block and section verify counts keep their real defaults so that their lengths are checked as built.
  flash_mass_erase_sequencer #(.EV_ALL_CYCLES(8), .PGM4_PE_CYCLES(3), .PGM4_BUS_CYCLES(8),
    .ERASE_PE_CYCLES(4), .ERASE_BUS_CYCLES(8)) u_flash_mass_erase_sequencer (.*);
  erase_requester u_erase_requester (.*);

  // ----------------------------------------------------------------
  // Clock, program/erase ticks and monitors
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  always @(negedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    pe_tick <= (tick_cnt == 2'h3);
  end
  always @(posedge clk) saw = saw | ({array_erase, array_verify, array_program} & {3{mass_erase_pending}});

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic ld);
    resetn = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    divider_write = ld;
    @(negedge clk);
    divider_write = 1'b0;
    @(negedge clk);
  endtask
  task automatic launch(input cmd_type c, input logic [2:0] i);
    cmd_req = '{1'b1, c, i};
    @(negedge clk);
    cmd_req.launch = 1'b0;
  endtask
  task automatic wait_idle;
    len = 0;
    @(negedge clk);
    while (busy !== 1'b0 && len < 40000) begin
      len++;
      @(negedge clk);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    foreach (rows[i]) begin
      r = rows[i];
      do_reset(1'b1);
      mode_permits_erase_all = r.mode;
      pflash_protected = r.pp;
      eeprom_protected = r.ep;
      verify_result = r.vr;
      launch(r.code, r.idx);
      wait_idle();
      check(flash_status_reg, r.st);
      check(security_state_field, r.sec);
      check(security_byte, r.sec == SEC_UNSECURED ? SEC_BYTE_UNSECURED : SEC_BYTE_SECURED);
      if (r.n != 0) begin
        if (base < 0) base = len - r.n;
        check(len - r.n, base);
      end
    end
    // Pin erase over full protection, verify pass then uncorrectable failure.
    for (int k = 0; k < 2; k++) begin
      do_reset(1'b1);
      mode_permits_erase_all = 1'b1;
      pflash_protected = 1'b1;
      eeprom_protected = 1'b1;
      verify_result = k ? 2'h3 : 2'h0;
      saw = 3'h0;
      go <= 1'b1;
      repeat (4) @(negedge clk);
      check(mass_erase_pending, 1'b1);
      wait_idle();
      go <= 1'b0;
      check(saw, k ? 3'h6 : 3'h7);
      check(mass_erase_pending, 1'b0);
      check(security_state_field, k ? SEC_SECURED : SEC_UNSECURED);
      check(security_byte, k ? SEC_BYTE_SECURED : SEC_BYTE_UNSECURED);
      check(flash_status_reg, k ? 4'h3 : 4'h0);
      check({divider_loaded, nvm_clock_divider}, {1'b0, DIVIDER_RESET});
      launch(CMD_ERASE_VERIFY_SECTION, 3'h0);
      @(negedge clk);
      check(flash_status_reg.access_error_flag, 1'b1);
      check(busy, 1'b0);
    end
    // Pin refused: divider never loaded, then mode forbids erase-all.
    for (int k = 0; k < 2; k++) begin
      do_reset(k[0]);
      mode_permits_erase_all = !k[0];
      go <= 1'b1;
      repeat (4) @(negedge clk);
      go <= 1'b0;
      check(flash_status_reg.access_error_flag, 1'b1);
      check({busy, mass_erase_pending}, 2'h0);
    end
    // Reset in the middle of a pin erase returns every output to its reset value.
    do_reset(1'b1);
    mode_permits_erase_all = 1'b1;
    go <= 1'b1;
    repeat (8) @(negedge clk);
    check({busy, mass_erase_pending}, 2'h3);
    go <= 1'b0;
    do_reset(1'b0);
    check({busy, mass_erase_pending, flash_status_reg}, 6'h00);
    check({divider_loaded, nvm_clock_divider}, {1'b0, DIVIDER_RESET});
    check({security_state_field, security_byte}, {SEC_SECURED, SEC_BYTE_SECURED});
    check({array_erase, array_verify, array_program}, 3'h0);
    tally_and_finish();
  end
endmodule // flash_mass_erase_sequencer_tb_top
